//--- core/ewc_device.sv
// drive end: taskfile, extended dma write execution and media hand-off
//
// Overview of operation
// RQ1: command 3D is forced-unit-access extended write
// RQ2: command 35 is plain extended dma write
// RQ3: forced write commits media before ending status
// RQ4: sector data moves as 16-bit words
// RQ5: host prepares dma channel before command
// RQ6: words move only while dma request high
// RQ7: one interrupt per command, after status
// RQ8: unrecoverable error stops at failing sector
// RQ9: sector count previous byte is high
// RQ10: zero sector count means 65536 sectors
// RQ11: address bytes current low, previous high
// RQ12: failing address read back through high select
// RQ13: host writes previous byte, current, command last
// RQ14: busy and fault clear; error causes flagged
`timescale 1ns/1ps
`include "ewc_map.svh"
module ewc_device #(
    parameter int WORDS_PER_SECTOR = 256,
    parameter logic [47:0] MAX_LBA = 48'h0000_FFFF_FFFF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    ewc_if.dev link,
    input wire logic cache_en_i,
    input wire logic med_err_i,
    input wire logic crc_err_i,
    input wire logic flush_done_i,
    output logic [15:0] med_data_o,
    output logic med_valid_o,
    output logic [47:0] med_lba_o,
    output logic flush_req_o,
    output logic busy_o
);
    import ewc_pkg::*;

    localparam logic [15:0] LAST_WORD = 16'(WORDS_PER_SECTOR - 1);

    ewc_dev_regs_t regs_ff;
    ewc_dev_regs_t nxt_regs;

    // maps a paired taskfile address onto its byte slot
    function automatic logic [1:0] ewc_slot(input logic [3:0] addr);
        logic [3:0] d;
        d = addr - `EWC_TF_BASE;
        return d[1:0];
    endfunction

    function automatic logic ewc_paired(input logic [3:0] addr);
        return addr >= `EWC_TF_SC && addr <= `EWC_TF_CH;
    endfunction

    // status byte built from live state
    function automatic logic [7:0] ewc_status(input ewc_dev_regs_t r);
        logic [7:0] s;
        s = 8'h00;
        s[`EWC_ST_BSY] = r.state != EWC_D_IDLE; // RQ14
        s[`EWC_ST_RDY] = 1'b1;
        s[`EWC_ST_DF] = 1'b0; // RQ14
        s[`EWC_ST_DSC] = 1'b1;
        s[`EWC_ST_DRQ] = r.state == EWC_D_XFER;
        s[`EWC_ST_ERR] = r.stat_err;
        return s;
    endfunction

    // next-state logic for the whole drive end
    always_comb
    begin
        logic [3:0] a;
        logic [1:0] k;
        logic [48:0] last;
        logic [47:0] rep;
        logic [16:0] cnt;
        a = link.tf_addr;
        k = ewc_slot(link.tf_addr);
        last = 49'h0;
        rep = 48'h0;
        cnt = 17'h0;
        nxt_regs = regs_ff;
        nxt_regs.med_valid = 1'b0;

        // register reads: answer one cycle after the strobe
        if (link.tf_rd)
        begin
            if (ewc_paired(a))
            begin
                nxt_regs.rdata = regs_ff.high_order_select ? regs_ff.prev[k] : regs_ff.cur[k]; // RQ12
            end
            else if (a == `EWC_TF_ERR)
            begin
                nxt_regs.rdata = regs_ff.err;
            end
            else if (a == `EWC_TF_CMD)
            begin
                nxt_regs.rdata = ewc_status(regs_ff);
                nxt_regs.intrq_pend = 1'b0; // reading status acknowledges the interrupt
            end
            else if (a == `EWC_TF_DEVCTL)
            begin
                nxt_regs.rdata = ewc_status(regs_ff);
            end
            else
            begin
                nxt_regs.rdata = 8'h00;
            end
        end

        // device control is taken at any time
        if (link.tf_wr && a == `EWC_TF_DEVCTL)
        begin
            nxt_regs.high_order_select = link.tf_wdata[`EWC_DC_HOB];
            nxt_regs.nien = link.tf_wdata[`EWC_DC_NIEN];
        end

        case (regs_ff.state)
            EWC_D_IDLE:
            begin
                // each paired write pushes the older byte into previous
                if (link.tf_wr && ewc_paired(a))
                begin
                    nxt_regs.prev[k] = regs_ff.cur[k]; // RQ9 RQ11 RQ13
                    nxt_regs.cur[k] = link.tf_wdata;
                    nxt_regs.high_order_select = 1'b0;
                end
                else if (link.tf_wr && a == `EWC_TF_CMD)
                begin
                    nxt_regs.err = 8'h00;
                    nxt_regs.stat_err = 1'b0;
                    nxt_regs.intrq_pend = 1'b0;
                    nxt_regs.high_order_select = 1'b0;
                    nxt_regs.wcnt = 16'h0000;
                    nxt_regs.lba = {regs_ff.prev[3], regs_ff.prev[2], regs_ff.prev[1],
                                    regs_ff.cur[3], regs_ff.cur[2], regs_ff.cur[1]}; // RQ11
                    cnt = {1'b0, regs_ff.prev[0], regs_ff.cur[0]}; // RQ9
                    if (cnt == 17'h0)
                    begin
                        cnt = `EWC_CNT_ZERO_SECT; // RQ10
                    end
                    nxt_regs.remain = cnt;
                    nxt_regs.fua = link.tf_wdata == `EWC_CMD_WR_FUA; // RQ1
                    last = {1'b0, nxt_regs.lba} + {32'h0, cnt} - 49'h1;
                    if (link.tf_wdata != `EWC_CMD_WR_FUA && link.tf_wdata != `EWC_CMD_WR_EXT) // RQ1 RQ2
                    begin
                        nxt_regs.err[`EWC_ER_ABT] = 1'b1; // RQ14
                        nxt_regs.stat_err = 1'b1;
                        nxt_regs.state = EWC_D_DONE;
                    end
                    else if (last > {1'b0, MAX_LBA})
                    begin
                        nxt_regs.err[`EWC_ER_IDN] = 1'b1; // RQ14
                        nxt_regs.stat_err = 1'b1;
                        nxt_regs.state = EWC_D_DONE;
                    end
                    else
                    begin
                        nxt_regs.state = EWC_D_XFER; // RQ5
                    end
                end
            end
            EWC_D_XFER:
            begin
                if (crc_err_i)
                begin
                    nxt_regs.err[`EWC_ER_CRC] = 1'b1; // RQ14
                    nxt_regs.err[`EWC_ER_ABT] = 1'b1;
                    nxt_regs.stat_err = 1'b1;
                    nxt_regs.state = EWC_D_DONE;
                end
                else if (med_err_i)
                begin
                    // stop here; lba still names the failing sector
                    nxt_regs.err[`EWC_ER_ABT] = 1'b1; // RQ8
                    nxt_regs.stat_err = 1'b1;
                    nxt_regs.state = EWC_D_DONE;
                end
                else if (link.dma_wr)
                begin
                    nxt_regs.med_data = link.dma_data; // RQ4 RQ6
                    nxt_regs.med_valid = 1'b1;
                    if (regs_ff.wcnt == LAST_WORD)
                    begin
                        nxt_regs.wcnt = 16'h0000;
                        nxt_regs.lba = regs_ff.lba + 48'h1;
                        nxt_regs.remain = regs_ff.remain - 17'h1;
                        if (regs_ff.remain == 17'h1)
                        begin
                            // forced unit access always waits for the media
                            if (regs_ff.fua || !cache_en_i) // RQ3
                            begin
                                nxt_regs.state = EWC_D_FLUSH;
                            end
                            else
                            begin
                                nxt_regs.state = EWC_D_DONE;
                            end
                        end
                    end
                    else
                    begin
                        nxt_regs.wcnt = regs_ff.wcnt + 16'h1;
                    end
                end
            end
            EWC_D_FLUSH:
            begin
                nxt_regs.flush_req = 1'b1;
                if (flush_done_i)
                begin
                    nxt_regs.flush_req = 1'b0; // RQ3
                    nxt_regs.state = EWC_D_DONE;
                end
            end
            EWC_D_DONE:
            begin
                // report failing sector on error, last written one otherwise
                rep = regs_ff.stat_err ? regs_ff.lba : regs_ff.lba - 48'h1; // RQ12
                nxt_regs.cur[1] = rep[7:0];
                nxt_regs.cur[2] = rep[15:8];
                nxt_regs.cur[3] = rep[23:16];
                nxt_regs.prev[1] = rep[31:24];
                nxt_regs.prev[2] = rep[39:32];
                nxt_regs.prev[3] = rep[47:40];
                nxt_regs.intrq_pend = 1'b1; // RQ7
                nxt_regs.state = EWC_D_IDLE;
            end
            default:
            begin
                nxt_regs.state = EWC_D_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            regs_ff <= '0;
        end
        else
        begin
            regs_ff <= nxt_regs;
        end
    end

    // link and user outputs
    assign link.tf_rdata = regs_ff.rdata;
    assign link.dmarq = regs_ff.state == EWC_D_XFER; // RQ6
    assign link.intrq = regs_ff.intrq_pend && !regs_ff.nien; // RQ7
    assign med_data_o = regs_ff.med_data;
    assign med_valid_o = regs_ff.med_valid;
    assign med_lba_o = regs_ff.lba;
    assign flush_req_o = regs_ff.flush_req;
    assign busy_o = regs_ff.state != EWC_D_IDLE;
endmodule // ewc_device

//--- core/ewc_host.sv
// controller end: wishbone registers, taskfile loading and slave dma source
`timescale 1ns/1ps
`include "ewc_map.svh"
module ewc_host (
    input wire logic clk_i,
    input wire logic rst_i,
    ewc_if.host link,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] src_data_i,
    input wire logic src_valid_i,
    output logic src_ready_o,
    output logic irq_o
);
    import ewc_pkg::*;

    ewc_host_regs_t regs_ff;
    ewc_host_regs_t nxt_regs;
    logic dma_go;

    // taskfile load order: previous byte, current byte, command last
    function automatic logic [11:0] ewc_setup(input logic [3:0] s, input ewc_host_regs_t r);
        case (s)
            4'h0: return {`EWC_TF_SC, r.count[15:8]};
            4'h1: return {`EWC_TF_SC, r.count[7:0]};
            4'h2: return {`EWC_TF_SN, r.lba[31:24]};
            4'h3: return {`EWC_TF_SN, r.lba[7:0]};
            4'h4: return {`EWC_TF_CL, r.lba[39:32]};
            4'h5: return {`EWC_TF_CL, r.lba[15:8]};
            4'h6: return {`EWC_TF_CH, r.lba[47:40]};
            4'h7: return {`EWC_TF_CH, r.lba[23:16]};
            4'h8: return {`EWC_TF_DEVHD, `EWC_DEVHD_LBA};
            default: return {`EWC_TF_CMD, r.fua ? `EWC_CMD_WR_FUA : `EWC_CMD_WR_EXT};
        endcase
    endfunction

    // a word moves only while the drive requests it
    assign dma_go = regs_ff.state == EWC_H_DMA && link.dmarq && src_valid_i; // RQ6

    // next-state logic: bus slave, sequencer and event flags
    always_comb
    begin
        logic [1:0] set;
        logic [1:0] clr;
        logic req;
        set = 2'b00;
        clr = 2'b00;
        req = wb_cyc_i && wb_stb_i && !regs_ff.ack;
        nxt_regs = regs_ff;
        nxt_regs.ack = req;
        nxt_regs.tf_wr = 1'b0;
        nxt_regs.tf_rd = 1'b0;

        if (req && wb_we_i && wb_sel_i == 4'hF)
        begin
            case (wb_adr_i)
                `EWC_WB_CTRL:
                begin
                    nxt_regs.fua = wb_dat_i[`EWC_CTRL_FUA];
                    if (wb_dat_i[`EWC_CTRL_GO] && regs_ff.state == EWC_H_IDLE)
                    begin
                        nxt_regs.state = EWC_H_SETUP;
                        nxt_regs.step = 4'h0;
                    end
                end
                `EWC_WB_COUNT: nxt_regs.count = wb_dat_i[15:0];
                `EWC_WB_LBA_LO: nxt_regs.lba[31:0] = wb_dat_i;
                `EWC_WB_LBA_HI: nxt_regs.lba[47:32] = wb_dat_i[15:0];
                `EWC_WB_IRQ_CLR: clr = wb_dat_i[1:0];
                `EWC_WB_IRQ_EN: nxt_regs.irq_en = wb_dat_i[1:0];
                default: nxt_regs.dat = regs_ff.dat;
            endcase
        end
        if (req && !wb_we_i)
        begin
            case (wb_adr_i)
                `EWC_WB_CTRL: nxt_regs.dat = {30'h0, regs_ff.fua, regs_ff.state != EWC_H_IDLE};
                `EWC_WB_COUNT: nxt_regs.dat = {16'h0, regs_ff.count};
                `EWC_WB_LBA_LO: nxt_regs.dat = regs_ff.lba[31:0];
                `EWC_WB_LBA_HI: nxt_regs.dat = {16'h0, regs_ff.lba[47:32]};
                `EWC_WB_RESULT: nxt_regs.dat = {16'h0, regs_ff.dev_error, regs_ff.dev_status};
                `EWC_WB_IRQ_STAT: nxt_regs.dat = {30'h0, regs_ff.irq_stat};
                `EWC_WB_IRQ_EN: nxt_regs.dat = {30'h0, regs_ff.irq_en};
                default: nxt_regs.dat = 32'h0;
            endcase
        end

        case (regs_ff.state)
            EWC_H_IDLE:
            begin
                nxt_regs.step = 4'h0;
            end
            EWC_H_SETUP:
            begin
                // one taskfile write per cycle
                {nxt_regs.tf_addr, nxt_regs.tf_wdata} = ewc_setup(regs_ff.step, regs_ff); // RQ13 RQ9 RQ11
                nxt_regs.tf_wr = 1'b1;
                nxt_regs.step = regs_ff.step + 4'h1;
                if (regs_ff.step == `EWC_SETUP_LAST)
                begin
                    nxt_regs.state = EWC_H_DMA; // RQ5
                end
            end
            EWC_H_DMA:
            begin
                nxt_regs.step = 4'h0;
                if (link.intrq)
                begin
                    nxt_regs.state = EWC_H_RESULT; // RQ7
                end
            end
            EWC_H_RESULT:
            begin
                // read status then error; data arrives a cycle after each strobe
                nxt_regs.step = regs_ff.step + 4'h1;
                nxt_regs.tf_rd = regs_ff.step < 4'h2;
                nxt_regs.tf_addr = regs_ff.step == 4'h0 ? `EWC_TF_CMD : `EWC_TF_ERR;
                if (regs_ff.step == 4'h2)
                begin
                    nxt_regs.dev_status = link.tf_rdata;
                end
                if (regs_ff.step == `EWC_RES_LAST)
                begin
                    nxt_regs.dev_error = link.tf_rdata;
                    set[`EWC_IRQ_DONE] = 1'b1;
                    set[`EWC_IRQ_FAIL] = regs_ff.dev_status[`EWC_ST_ERR];
                    nxt_regs.state = EWC_H_IDLE;
                end
            end
            default:
            begin
                nxt_regs.state = EWC_H_IDLE;
            end
        endcase
        // a new event wins over a clear in the same cycle
        nxt_regs.irq_stat = (regs_ff.irq_stat & ~clr) | set;
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            regs_ff <= '0;
        end
        else
        begin
            regs_ff <= nxt_regs;
        end
    end

    assign link.tf_wr = regs_ff.tf_wr;
    assign link.tf_rd = regs_ff.tf_rd;
    assign link.tf_addr = regs_ff.tf_addr;
    assign link.tf_wdata = regs_ff.tf_wdata;
    assign link.dma_wr = dma_go; // RQ6
    assign link.dma_data = src_data_i; // RQ4
    assign src_ready_o = dma_go;
    assign wb_dat_o = regs_ff.dat;
    assign wb_ack_o = regs_ff.ack;
    assign irq_o = |(regs_ff.irq_stat & regs_ff.irq_en);
endmodule // ewc_host

//--- core/ewc_if.sv
// taskfile, slave dma and interrupt wires between controller and drive
`timescale 1ns/1ps
interface ewc_if;
    logic tf_wr;
    logic tf_rd;
    logic [3:0] tf_addr;
    logic [7:0] tf_wdata;
    logic [7:0] tf_rdata;
    logic dmarq;
    logic dma_wr;
    logic [15:0] dma_data;
    logic intrq;
    modport dev (input tf_wr, tf_rd, tf_addr, tf_wdata, dma_wr, dma_data,
                 output tf_rdata, dmarq, intrq);
    modport host (output tf_wr, tf_rd, tf_addr, tf_wdata, dma_wr, dma_data,
                  input tf_rdata, dmarq, intrq);
endinterface

//--- core/ewc_map.svh
// register map, bit positions and command codes of the extended write handler
`ifndef EWC_MAP_SVH
`define EWC_MAP_SVH
`define EWC_CMD_WR_EXT 8'h35
`define EWC_CMD_WR_FUA 8'h3D
`define EWC_TF_ERR 4'h1
`define EWC_TF_SC 4'h2
`define EWC_TF_SN 4'h3
`define EWC_TF_CL 4'h4
`define EWC_TF_CH 4'h5
`define EWC_TF_DEVHD 4'h6
`define EWC_TF_CMD 4'h7
`define EWC_TF_DEVCTL 4'hE
`define EWC_TF_BASE 4'h2
`define EWC_DEVHD_LBA 8'h40
`define EWC_DC_HOB 7
`define EWC_DC_NIEN 1
`define EWC_ST_BSY 7
`define EWC_ST_RDY 6
`define EWC_ST_DF 5
`define EWC_ST_DSC 4
`define EWC_ST_DRQ 3
`define EWC_ST_ERR 0
`define EWC_ER_CRC 7
`define EWC_ER_UNC 6
`define EWC_ER_IDN 4
`define EWC_ER_ABT 2
`define EWC_CNT_ZERO_SECT 17'h10000
`define EWC_WB_CTRL 8'h00
`define EWC_WB_COUNT 8'h04
`define EWC_WB_LBA_LO 8'h08
`define EWC_WB_LBA_HI 8'h0C
`define EWC_WB_RESULT 8'h10
`define EWC_WB_IRQ_STAT 8'h14
`define EWC_WB_IRQ_CLR 8'h18
`define EWC_WB_IRQ_EN 8'h1C
`define EWC_CTRL_GO 0
`define EWC_CTRL_FUA 1
`define EWC_IRQ_DONE 0
`define EWC_IRQ_FAIL 1
`define EWC_SETUP_LAST 4'h9
`define EWC_RES_LAST 4'h3
`endif

//--- core/ewc_pkg.sv
// types shared by both ends of the extended write handler
package ewc_pkg;
    typedef enum logic [1:0] {
        EWC_D_IDLE = 2'h0,
        EWC_D_XFER = 2'h1,
        EWC_D_FLUSH = 2'h3,
        EWC_D_DONE = 2'h2
    } ewc_dev_state_t;
    typedef enum logic [1:0] {
        EWC_H_IDLE = 2'h0,
        EWC_H_SETUP = 2'h1,
        EWC_H_DMA = 2'h3,
        EWC_H_RESULT = 2'h2
    } ewc_host_state_t;
    typedef struct packed {
        ewc_dev_state_t state;
        logic [3:0][7:0] cur;
        logic [3:0][7:0] prev;
        logic high_order_select;
        logic nien;
        logic fua;
        logic [16:0] remain;
        logic [47:0] lba;
        logic [15:0] wcnt;
        logic [7:0] err;
        logic stat_err;
        logic intrq_pend;
        logic [7:0] rdata;
        logic [15:0] med_data;
        logic med_valid;
        logic flush_req;
    } ewc_dev_regs_t;
    typedef struct packed {
        ewc_host_state_t state;
        logic [3:0] step;
        logic fua;
        logic [15:0] count;
        logic [47:0] lba;
        logic tf_wr;
        logic tf_rd;
        logic [3:0] tf_addr;
        logic [7:0] tf_wdata;
        logic [7:0] dev_status;
        logic [7:0] dev_error;
        logic [1:0] irq_stat;
        logic [1:0] irq_en;
        logic ack;
        logic [31:0] dat;
    } ewc_host_regs_t;
endpackage

//--- verif/ewc_assertions.sv
// concurrent checks on the taskfile, dma and interrupt wires
`timescale 1ns/1ps
`include "ewc_map.svh"
module ewc_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tf_wr,
    input wire logic tf_rd,
    input wire logic [3:0] tf_addr,
    input wire logic [7:0] tf_wdata,
    input wire logic [7:0] tf_rdata,
    input wire logic dmarq,
    input wire logic dma_wr,
    input wire logic [15:0] dma_data,
    input wire logic intrq
);
    logic [1:0] cmd_ff;
    logic [1:0] strd_ff;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // history of command writes and status reads
    always_ff @(posedge clk_i)
    begin
        cmd_ff <= {cmd_ff[0], tf_wr && tf_addr == `EWC_TF_CMD};
        strd_ff <= {strd_ff[0], tf_rd && tf_addr == `EWC_TF_CMD};
    end
    // one paired register: previous byte, then current byte
    sequence s_pair(logic [3:0] a);
        (tf_wr && tf_addr == a) [*2];
    endsequence
    // whole load with the command byte last
    sequence s_setup;
        s_pair(`EWC_TF_SC) ##1 s_pair(`EWC_TF_SN) ##1 s_pair(`EWC_TF_CL) ##1 s_pair(`EWC_TF_CH)
        ##1 (tf_wr && tf_addr == `EWC_TF_DEVHD) ##1 (tf_wr && tf_addr == `EWC_TF_CMD);
    endsequence
    a_setup_order:
        assert property (tf_wr && tf_addr == `EWC_TF_SC && !$past(tf_wr) |-> s_setup)
        else $error("taskfile load out of order");
    a_cmd_code:
        assert property (tf_wr && tf_addr == `EWC_TF_CMD |-> tf_wdata inside {`EWC_CMD_WR_EXT, `EWC_CMD_WR_FUA})
        else $error("unexpected command code");
    a_dma_qual:
        assert property (dma_wr |-> dmarq)
        else $error("data word moved without dma request");
    a_req_after_cmd:
        assert property ($rose(dmarq) |-> cmd_ff != 2'h0)
        else $error("dma request not started by a command");
    a_irq_quiet:
        assert property (intrq |-> !dmarq && !dma_wr)
        else $error("interrupt while data still moving");
    a_irq_clear:
        assert property ($fell(intrq) |-> strd_ff != 2'h0)
        else $error("interrupt dropped without status read");
    a_stat_fixed:
        assert property (tf_rd && tf_addr == `EWC_TF_CMD |=> tf_rdata[6:4] == 3'h5)
        else $error("status ready, fault or seek bits wrong");
    a_busy_done:
        assert property (intrq && tf_rd && tf_addr == `EWC_TF_CMD |=> !tf_rdata[`EWC_ST_BSY])
        else $error("busy still set at completion");
    c_data: cover property (dma_wr);
endmodule // ewc_assertions

//--- verif/tb_ext_dma_write_command_handler.sv
// self-checking bench: controller and drive over the taskfile link
`timescale 1ns/1ps
`include "ewc_map.svh"
module tb_ext_dma_write_command_handler;
    localparam int WPS = 4;
    localparam logic [47:0] MAXL = 48'h7FFF_FFFF_FFFF;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, src_ready_o, irq_o, src_valid_i = 1'b0, src_on = 1'b1, stall = 1'b0;
    logic [15:0] src_data_i = 16'hA000, exp_word = 16'hA000, med_data_o;
    logic cache_en_i = 1'b0, med_err_i = 1'b0, crc_err_i = 1'b0, flush_done_i = 1'b0;
    logic med_valid_o, flush_req_o, busy_o, flush_seen = 1'b0, irq_d = 1'b0;
    logic [47:0] med_lba_o, cmd_lba = 48'h0;
    int miscompares = 0, check_count = 0, cycles = 0, srcn = 0, stop_at = 1 << 30, wcmd = 0, nint = 0, fcnt = 0;
    ewc_if link();
    ewc_device #(.WORDS_PER_SECTOR(WPS), .MAX_LBA(MAXL)) ewc_device_inst (.clk_i(clk_i), .rst_i(rst_i),
        .link(link), .cache_en_i(cache_en_i), .med_err_i(med_err_i), .crc_err_i(crc_err_i),
        .flush_done_i(flush_done_i), .med_data_o(med_data_o), .med_valid_o(med_valid_o),
        .med_lba_o(med_lba_o), .flush_req_o(flush_req_o), .busy_o(busy_o));
    ewc_host ewc_host_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_data_i(src_data_i),
        .src_valid_i(src_valid_i), .src_ready_o(src_ready_o), .irq_o(irq_o));
    ewc_assertions chk_inst (.clk_i(clk_i), .rst_i(rst_i), .tf_wr(link.tf_wr), .tf_rd(link.tf_rd),
        .tf_addr(link.tf_addr), .tf_wdata(link.tf_wdata), .tf_rdata(link.tf_rdata), .dmarq(link.dmarq),
        .dma_wr(link.dma_wr), .dma_data(link.dma_data), .intrq(link.intrq));
    // 25 mhz clock
    initial
    begin
        forever #20 clk_i = ~clk_i;
    end
    // compare one value and count it
    task automatic chk(input logic [47:0] s, input logic [47:0] e);
        check_count++;
        if (s !== e)
        begin
            miscompares++;
            $display("FAIL %0t seen %0h expected %0h", $time, s, e);
        end
    endtask
    // counts and verdict, then stop
    task results;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one classic wishbone cycle, held until ack
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dw, input logic [3:0] sl,
                      output logic [31:0] dr);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, a, dw, sl};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        dr = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
        @(posedge clk_i);
    endtask
    // word source, media flush responder, data monitor and timeout
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        fcnt <= flush_req_o ? fcnt + 1 : 0;
        flush_done_i <= flush_req_o && fcnt == 5;
        if (flush_req_o)
            flush_seen <= 1'b1;
        if (flush_req_o)
            chk(link.intrq, 1'b0);
        irq_d <= link.intrq;
        if (link.intrq && !irq_d)
            nint <= nint + 1;
        if (src_ready_o)
        begin
            srcn <= srcn + 1;
            src_data_i <= src_data_i + 16'h1;
        end
        src_valid_i <= src_on && !(stall && src_ready_o) && srcn + int'(src_ready_o) != stop_at;
        if (med_valid_o)
        begin
            chk(med_data_o, exp_word);
            if (wcmd % WPS == 1)
                chk(med_lba_o, cmd_lba + 48'(wcmd / WPS));
            exp_word <= exp_word + 16'h1;
            wcmd <= wcmd + 1;
        end
        if (cycles == 30000)
        begin
            miscompares++;
            results();
        end
    end
    // one command, load to irq clear; ek 1 media error, 2 crc error, 3 no flush check
    task automatic run(input logic fua, cache, input logic [15:0] cnt, input logic [47:0] lba,
                       input logic stl, input int ek, stopw, words, input logic [7:0] eerr, input logic fl);
        logic [31:0] d;
        flush_seen = 1'b0;
        wcmd = 0;
        nint = 0;
        cmd_lba = lba;
        stall <= stl;
        cache_en_i <= cache;
        if (ek == 1 || ek == 2)
            stop_at = srcn + stopw;
        wb(1'b1, `EWC_WB_IRQ_EN, 32'h0, 4'hF, d);
        wb(1'b1, `EWC_WB_COUNT, {16'h0, cnt}, 4'hF, d);
        wb(1'b1, `EWC_WB_LBA_LO, lba[31:0], 4'hF, d);
        wb(1'b1, `EWC_WB_LBA_HI, {16'h0, lba[47:32]}, 4'hF, d);
        wb(1'b1, `EWC_WB_CTRL, {30'h0, fua, 1'b1}, 4'hF, d);
        if (ek == 1 || ek == 2)
        begin
            while (srcn != stop_at) @(posedge clk_i);
            repeat (3) @(posedge clk_i);
            med_err_i <= ek == 1;
            crc_err_i <= ek == 2;
        end
        d = 32'h0;
        while (d[1:0] == 2'h0) wb(1'b0, `EWC_WB_IRQ_STAT, 32'h0, 4'hF, d);
        {med_err_i, crc_err_i} <= 2'h0;
        stop_at = 1 << 30;
        chk(irq_o, 1'b0);
        chk(d[1:0], {eerr != 8'h0, 1'b1});
        chk(nint, 1);
        chk(wcmd, words);
        if (ek == 0)
            chk(flush_seen, fl);
        wb(1'b0, `EWC_WB_RESULT, 32'h0, 4'hF, d);
        chk(d[15:0], {eerr, 7'h28, eerr != 8'h0});
        chk({ewc_device_inst.regs_ff.prev[3:1], ewc_device_inst.regs_ff.cur[3:1]},
            lba + 48'(words / WPS) - 48'(!ek));
        wb(1'b1, `EWC_WB_IRQ_EN, 32'h3, 4'hF, d);
        chk(irq_o, 1'b1);
        wb(1'b1, `EWC_WB_IRQ_CLR, 32'h3, 4'hF, d);
        chk(irq_o, 1'b0);
    endtask
    // reset values, unmapped read, partial-select write ignored
    task automatic t_regs;
        logic [31:0] d;
        wb(1'b0, `EWC_WB_IRQ_STAT, 32'h0, 4'hF, d);
        chk(d, 32'h0);
        wb(1'b0, 8'h40, 32'h0, 4'hF, d);
        chk(d, 32'h0);
        wb(1'b1, `EWC_WB_COUNT, 32'h1234, 4'hF, d);
        wb(1'b1, `EWC_WB_COUNT, 32'h5678, 4'h1, d);
        wb(1'b0, `EWC_WB_COUNT, 32'h0, 4'hF, d);
        chk(d[15:0], 16'h1234);
        chk({irq_o, busy_o}, 2'h0);
    endtask
    // plain write, cache on, two sectors, no flush
    task t_plain;
        run(1'b0, 1'b1, 16'h0002, 48'h0012_3456_789A, 1'b0, 0, 0, 2 * WPS, 8'h00, 1'b0);
    endtask
    // forced write with a stalling source commits before status
    task t_fua;
        run(1'b1, 1'b1, 16'h0001, 48'h5A00_0000_0010, 1'b1, 0, 0, WPS, 8'h00, 1'b1);
    endtask
    // plain write with cache off also flushes
    task t_nocache;
        run(1'b0, 1'b0, 16'h0003, 48'h0000_0102_0304, 1'b0, 0, 0, 3 * WPS, 8'h00, 1'b1);
    endtask
    // zero count runs past two sectors, media error stops it
    task t_zero_med;
        run(1'b0, 1'b1, 16'h0000, 48'h0000_0000_0100, 1'b0, 1, 2 * WPS, 2 * WPS, 8'h04, 1'b0);
    endtask
    // crc fault in mid-command
    task t_crc;
        run(1'b1, 1'b1, 16'h0004, 48'h0000_0000_0200, 1'b1, 2, WPS, WPS, 8'h84, 1'b0);
    endtask
    // range past the last sector refused without transfer
    task t_range;
        run(1'b0, 1'b1, 16'h0002, MAXL, 1'b0, 3, 0, 0, 8'h10, 1'b0);
    endtask
    // main sequence
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_plain();
        t_fua();
        t_nocache();
        t_zero_med();
        t_crc();
        t_range();
        results();
    end
endmodule // tb_ext_dma_write_command_handler
